// >>> include/dic_defines.vh
// Purpose: Constants for the digital input conditioning block.
// Assumes: 200 MHz pclk; APB register access.
// Notes: Times are kept in microseconds, the save period in seconds; cycle counts derive from them.
//
// Behaviour
// - Supply short raises a unit error when supervision enabled; enabled by default.
// - Open channel raises a channel error when supervision enabled; off by default.
// - Inrush masking ignores excess current for 100 ms; off by default.
// - One unit filter time: 0.1, 1.0, 10 or 20 ms; default 1.0 ms.
// - Accepted input held for extension time: 1, 15, 100 or 200 ms; default 15.
// - Each channel counts how often its input switched ON.
// - Threshold enabled gives channel error when count exceeds setting; off by default.
// - Threshold setting is in units of one thousand operations.
// - Counts saved hourly to persistent storage; power-up resumes from saved value.
`ifndef DIC_DEFINES_VH
`define DIC_DEFINES_VH

`define DIC_CLK_MHZ        200
`define DIC_US_TO_CYC(u)   ((u) * `DIC_CLK_MHZ)

`define DIC_FILT_T0_US     100
`define DIC_FILT_T1_US     1000
`define DIC_FILT_T2_US     10000
`define DIC_FILT_T3_US     20000
`define DIC_EXT_T0_US      1000
`define DIC_EXT_T1_US      15000
`define DIC_EXT_T2_US      100000
`define DIC_EXT_T3_US      200000
`define DIC_INRUSH_US      100000
`define DIC_SAVE_PERIOD_S  3600
`define DIC_US_PER_S       64'd1000000
`define DIC_CNT_SCALE      1000
`define DIC_THR_MAX        16'hFDE8

`define DIC_REG_CTRL       12'h000
`define DIC_REG_THR        12'h004
`define DIC_REG_OCEN       12'h008
`define DIC_REG_STAT       12'h00C
`define DIC_REG_CHERR      12'h010
`define DIC_REG_INPUT      12'h014
`define DIC_REG_CNTSEL     12'h018
`define DIC_REG_CNT        12'h01C

`define DIC_CTRL_SC_EN     0
`define DIC_CTRL_INRUSH    1
`define DIC_CTRL_FILT_LO   2
`define DIC_CTRL_EXT_LO    4
`define DIC_CTRL_THR_EN    6
`define DIC_CTRL_RESET     32'h0000_0015
`define DIC_THR_RESET      16'h0001

`endif

// >>> hw/dic_channel.v
// Purpose: One input channel: filter, extension, ON counter and threshold check.
// Assumes: Input synchronous to pclk; filter and extension cycle counts come from the top.
// Notes: Counter width caps at all ones rather than wrapping.
`timescale 1ns/1ps
`default_nettype none
module dic_channel #(
    parameter CW = 32
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // Timing
    input  wire [31:0]   filt_cyc,
    input  wire [31:0]   ext_cyc,
    // Counter control
    input  wire          load,
    input  wire [CW-1:0] load_val,
    input  wire          thr_en,
    input  wire [CW-1:0] thr_cnt,
    // Field and results
    input  wire          raw_in,
    output reg           level,
    output reg           accepted,
    output reg  [CW-1:0] count,
    output reg           cnt_err
);
    reg  [31:0] fcnt;
    reg  [31:0] ecnt;
    wire        take          = (raw_in != accepted) && (fcnt + 32'h1 >= filt_cyc);
    wire        next_accepted = take ? raw_in : accepted;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt     <= 32'h0;
            ecnt     <= 32'h0;
            accepted <= 1'b0;
            level    <= 1'b0;
            count    <= {CW{1'b0}};
            cnt_err  <= 1'b0;
        end else begin
            if (raw_in == accepted) begin
                fcnt <= 32'h0;
            end else if (take) begin
                fcnt     <= 32'h0;
                accepted <= raw_in;
                if (raw_in && count != {CW{1'b1}}) begin
                    count <= count + {{(CW-1){1'b0}}, 1'b1};
                end
            end else begin
                fcnt <= fcnt + 32'h1;
            end
            // A new level shows at once and then stands for the whole extension time,
            // so a short pulse stays visible; later changes wait for the hold to end.
            if (ecnt == 32'h0 && level != next_accepted) begin
                level <= next_accepted;
                ecnt  <= ext_cyc;
            end else if (ecnt != 32'h0) begin
                ecnt <= ecnt - 32'h1;
            end
            if (load) begin
                count <= load_val;
            end
            cnt_err <= thr_en && (count > thr_cnt);
        end
    end
endmodule
`default_nettype wire

// >>> hw/dic_top.v
// Purpose: Digital input conditioning unit with APB register access.
// Assumes: One 200 MHz clock; persistent store reached through save and restore ports.
// Notes: APB answers with pready high in the access cycle, no wait states.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defines.vh"
module dic_top #(
    parameter NCH        = 8,
    parameter CW         = 32,
    parameter SAVE_CYC   = `DIC_US_PER_S * `DIC_SAVE_PERIOD_S * `DIC_CLK_MHZ,
    parameter INRUSH_CYC = `DIC_US_TO_CYC(`DIC_INRUSH_US)
) (
    // APB
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Field side
    input  wire [NCH-1:0] raw_in,
    input  wire [NCH-1:0] open_detect,
    input  wire          supply_short,
    input  wire          excess_current,
    input  wire          inrush_start,
    // Persistent store
    input  wire          restore_valid,
    input  wire [CW-1:0] restore_data,
    input  wire [7:0]    restore_ch,
    output reg           save_req,
    output reg  [7:0]    save_ch,
    output reg  [CW-1:0] save_data,
    // Results
    output reg  [NCH-1:0] input_level,
    output reg           unit_error,
    output reg  [NCH-1:0] chan_error
);
    reg [31:0]  ctrl;
    reg [15:0]  thr;
    reg [NCH-1:0] open_circuit_supervise_en;
    reg [7:0]   cnt_sel;
    reg [63:0]  save_tmr;
    reg         saving;
    reg [7:0]   save_idx;
    reg [31:0]  inrush_tmr;
    reg         sc_err;
    reg [31:0]  filt_cyc;
    reg [31:0]  ext_cyc;
    reg [31:0]  rd;

    wire [NCH-1:0]    lvl;
    wire [NCH-1:0]    cerr;
    wire [NCH*CW-1:0] cnts;

    wire       supply_short_supervise_en = ctrl[`DIC_CTRL_SC_EN];
    wire       inrush_en                 = ctrl[`DIC_CTRL_INRUSH];
    wire [1:0] filt_sel                  = ctrl[`DIC_CTRL_FILT_LO+1:`DIC_CTRL_FILT_LO];
    wire [1:0] input_extension_time_sel  = ctrl[`DIC_CTRL_EXT_LO+1:`DIC_CTRL_EXT_LO];
    wire       thr_en                    = ctrl[`DIC_CTRL_THR_EN];
    wire [CW-1:0] thr_cnt = thr * `DIC_CNT_SCALE;
    wire       wr = psel && penable && pwrite;
    wire       rd_acc = psel && !penable && !pwrite;

    function [CW-1:0] ch_cnt;
        input [NCH*CW-1:0] v;
        input [7:0]        i;
        begin
            // An index past the last channel reads zero instead of unknown bits.
            if (i < NCH) begin
                ch_cnt = v[i*CW +: CW];
            end else begin
                ch_cnt = {CW{1'b0}};
            end
        end
    endfunction

    always @* begin
        case (filt_sel)
            2'h0:    filt_cyc = `DIC_US_TO_CYC(`DIC_FILT_T0_US);
            2'h1:    filt_cyc = `DIC_US_TO_CYC(`DIC_FILT_T1_US);
            2'h2:    filt_cyc = `DIC_US_TO_CYC(`DIC_FILT_T2_US);
            default: filt_cyc = `DIC_US_TO_CYC(`DIC_FILT_T3_US);
        endcase
        case (input_extension_time_sel)
            2'h0:    ext_cyc = `DIC_US_TO_CYC(`DIC_EXT_T0_US);
            2'h1:    ext_cyc = `DIC_US_TO_CYC(`DIC_EXT_T1_US);
            2'h2:    ext_cyc = `DIC_US_TO_CYC(`DIC_EXT_T2_US);
            default: ext_cyc = `DIC_US_TO_CYC(`DIC_EXT_T3_US);
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            dic_channel #(.CW(CW)) u_ch (
                .pclk     (pclk),
                .presetn  (presetn),
                .filt_cyc (filt_cyc),
                .ext_cyc  (ext_cyc),
                .load     (restore_valid && restore_ch == g),
                .load_val (restore_data),
                .thr_en   (thr_en),
                .thr_cnt  (thr_cnt),
                .raw_in   (raw_in[g]),
                .level    (lvl[g]),
                .accepted (),
                .count    (cnts[g*CW +: CW]),
                .cnt_err  (cerr[g])
            );
        end
    endgenerate

    always @* begin
        case (paddr)
            `DIC_REG_CTRL:   rd = ctrl;
            `DIC_REG_THR:    rd = {16'h0, thr};
            `DIC_REG_OCEN:   rd = {{(32-NCH){1'b0}}, open_circuit_supervise_en};
            `DIC_REG_STAT:   rd = {31'h0, unit_error};
            `DIC_REG_CHERR:  rd = {{(32-NCH){1'b0}}, chan_error};
            `DIC_REG_INPUT:  rd = {{(32-NCH){1'b0}}, input_level};
            `DIC_REG_CNTSEL: rd = {24'h0, cnt_sel};
            `DIC_REG_CNT:    rd = ch_cnt(cnts, cnt_sel);
            default:         rd = 32'h0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= `DIC_CTRL_RESET;
            thr     <= `DIC_THR_RESET;
            open_circuit_supervise_en <= {NCH{1'b0}};
            cnt_sel <= 8'h0;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Ready is registered one cycle ahead so the access phase completes at once.
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > `DIC_REG_CNT);
            if (rd_acc) begin
                prdata <= rd;
            end
            if (wr && pready && !pslverr) begin
                case (paddr)
                    `DIC_REG_CTRL:   ctrl <= pwdata;
                    `DIC_REG_THR: begin
                        if (pwdata[15:0] != 16'h0 && pwdata[15:0] <= `DIC_THR_MAX) begin
                            thr <= pwdata[15:0];
                        end
                    end
                    `DIC_REG_OCEN:   open_circuit_supervise_en <= pwdata[NCH-1:0];
                    `DIC_REG_CNTSEL: cnt_sel <= pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Inrush window and supply supervision.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inrush_tmr <= 32'h0;
            sc_err     <= 1'b0;
            unit_error <= 1'b0;
        end else begin
            if (inrush_start && inrush_en) begin
                inrush_tmr <= INRUSH_CYC;
            end else if (inrush_tmr != 32'h0) begin
                inrush_tmr <= inrush_tmr - 32'h1;
            end
            sc_err     <= supply_short_supervise_en && supply_short;
            unit_error <= sc_err || (excess_current && inrush_tmr == 32'h0);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_level <= {NCH{1'b0}};
            chan_error  <= {NCH{1'b0}};
        end else begin
            input_level <= lvl;
            chan_error  <= (open_detect & open_circuit_supervise_en) | cerr;
        end
    end

    // Hourly save walks all channels one per cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_tmr  <= 64'h0;
            saving    <= 1'b0;
            save_idx  <= 8'h0;
            save_req  <= 1'b0;
            save_ch   <= 8'h0;
            save_data <= {CW{1'b0}};
        end else begin
            save_req <= 1'b0;
            if (save_tmr + 64'h1 >= SAVE_CYC) begin
                save_tmr <= 64'h0;
                saving   <= 1'b1;
                save_idx <= 8'h0;
            end else begin
                save_tmr <= save_tmr + 64'h1;
            end
            if (saving) begin
                save_req  <= 1'b1;
                save_ch   <= save_idx;
                save_data <= ch_cnt(cnts, save_idx);
                save_idx  <= save_idx + 8'h1;
                if (save_idx == NCH - 1) begin
                    saving <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/dic_top_monitor.sv
// Purpose: Port checker for dic_top.
// Assumes: CTRL and OCEN are shadowed from APB writes.
// Notes: A slack of a few cycles covers the lag of the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defines.vh"
module dic_top_monitor #(parameter NCH = 8, parameter SAVE_CYC = 64'd400) (
    // APB
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // Field side
    input wire logic [NCH-1:0] raw_in,
    input wire logic [NCH-1:0] open_detect,
    input wire logic           supply_short,
    input wire logic           excess_current,
    // Results
    input wire logic           save_req,
    input wire logic [7:0]     save_ch,
    input wire logic [NCH-1:0] input_level,
    input wire logic           unit_error,
    input wire logic [NCH-1:0] chan_error
);
    logic [6:0]     ctrl;
    logic [NCH-1:0] oc;
    logic [31:0]    stab, hi;
    logic [63:0]    gap;
    logic           prev;
    wire            wr = psel && penable && pready && pwrite;
    wire            cause = (ctrl[0] && supply_short) || excess_current;
    wire [31:0]     fc = `DIC_US_TO_CYC(ctrl[3] ? (ctrl[2] ? `DIC_FILT_T3_US : `DIC_FILT_T2_US)
                         : (ctrl[2] ? `DIC_FILT_T1_US : `DIC_FILT_T0_US));
    wire [31:0]     ec = `DIC_US_TO_CYC(ctrl[5] ? (ctrl[4] ? `DIC_EXT_T3_US : `DIC_EXT_T2_US)
                         : (ctrl[4] ? `DIC_EXT_T1_US : `DIC_EXT_T0_US));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 7'h15;
            oc <= '0;
            stab <= 32'h0;
            hi <= 32'h0;
            gap <= 64'h0;
            prev <= 1'b0;
        end else begin
            if (wr && paddr == `DIC_REG_CTRL) ctrl <= pwdata[6:0];
            if (wr && paddr == `DIC_REG_OCEN) oc <= pwdata[NCH-1:0];
            prev <= raw_in[0];
            stab <= (raw_in[0] != prev) ? 32'h0 : stab + 32'h1;
            hi <= input_level[0] ? hi + 32'h1 : 32'h0;
            gap <= save_req ? 64'h0 : gap + 64'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_bad;
        s_acc ##0 (paddr > `DIC_REG_CNT || paddr[1:0] != 2'h0);
    endsequence
    a_ready_access: assert property (s_acc |-> pready) else $error("no ready in access");
    a_ready_idle: assert property (!psel |-> !pready) else $error("ready while idle");
    a_bad_addr: assert property (s_bad |-> pslverr) else $error("bad address accepted");
    a_short_err: assert property (ctrl[0] && supply_short |-> ##[1:4] unit_error)
        else $error("short not flagged");
    a_err_cause: assert property ($rose(unit_error) |-> $past(cause) || $past(cause, 2)
        || $past(cause, 3)) else $error("unit error without cause");
    a_oc_err: assert property (|(oc & open_detect) |-> ##[1:4] |(chan_error & oc))
        else $error("open channel not flagged");
    a_filter_wait: assert property ($rose(input_level[0]) |-> stab >= fc - 2)
        else $error("input accepted too early");
    a_ext_hold: assert property ($fell(input_level[0]) |-> hi >= ec - 2)
        else $error("input released too early");
    a_save_pulse: assert property (save_req |=> !save_req || save_ch == $past(save_ch) + 8'h01)
        else $error("save walk broken");
    a_save_period: assert property (gap <= SAVE_CYC + 8) else $error("save overdue");
endmodule
bind dic_top dic_top_monitor #(.NCH(NCH), .SAVE_CYC(SAVE_CYC)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .raw_in(raw_in),
    .open_detect(open_detect), .supply_short(supply_short), .excess_current(excess_current),
    .save_req(save_req), .save_ch(save_ch), .input_level(input_level), .unit_error(unit_error),
    .chan_error(chan_error));
`default_nettype wire

// >>> verification/dic_sensor_model.sv
// Purpose: Switch contacts on the input channels.
// Assumes: A pulse on glitch starts one bounce.
// Notes: A bounce inverts every line, as a chattering common return would.
`timescale 1ns/1ps
`default_nettype none
module dic_sensor_model #(parameter NCH = 8) (
    // Control
    input  wire logic           pclk,
    input  wire logic [NCH-1:0] level,
    input  wire logic [15:0]    glitch,
    // Field lines
    output wire logic [NCH-1:0] raw
);
    logic [15:0] left = 16'h0000;
    always @(posedge pclk) begin
        if (glitch != 16'h0000)
            left <= glitch;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
    assign raw = (left != 16'h0000) ? ~level : level;
endmodule
`default_nettype wire

// >>> verification/dic_top_tb.sv
// Purpose: Self-checking bench for dic_top.
// Assumes: Shortened save period and inrush window.
// Notes: Extension times outlast the run, so only rising inputs are timed.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defines.vh"
module dic_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic        inrush_start = 0, restore_valid = 0, supply_short = 0, excess_current = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, restore_data = 0, d;
    logic [7:0]  open_detect = 0, lvl = 0, restore_ch = 0;
    logic [15:0] gl = 0;
    wire  [31:0] prdata, save_data;
    wire  [7:0]  raw, save_ch, input_level, chan_error;
    wire         pready, pslverr, save_req, unit_error;
    integer      seed = 32'h641eed99;
    int          n_errors = 0, compares = 0, cyc = 0, n, v;
    dic_top #(.NCH(8), .CW(32), .SAVE_CYC(64'd400), .INRUSH_CYC(50)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_in(raw), .open_detect(open_detect), .supply_short(supply_short),
        .excess_current(excess_current), .inrush_start(inrush_start),
        .restore_valid(restore_valid), .restore_data(restore_data), .restore_ch(restore_ch),
        .save_req(save_req), .save_ch(save_ch), .save_data(save_data),
        .input_level(input_level), .unit_error(unit_error), .chan_error(chan_error));
    dic_sensor_model #(.NCH(8)) u_sens (.pclk(pclk), .level(lvl), .glitch(gl), .raw(raw));
    function automatic int fcyc(input logic [1:0] s);
        return `DIC_US_TO_CYC(s == 0 ? `DIC_FILT_T0_US : s == 1 ? `DIC_FILT_T1_US
            : s == 2 ? `DIC_FILT_T2_US : `DIC_FILT_T3_US);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        tick(1);
        penable <= 1;
        do begin
            tick(1);
            k++;
        end while (pready !== 1'b1 && k < 20);
        d = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        tick(1);
        if (k >= 20) begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(d, e);
    endtask
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        tick(5);
        presetn <= 1;
        tick(1);
        rd(`DIC_REG_CTRL, (1 << `DIC_CTRL_SC_EN) | (1 << `DIC_CTRL_FILT_LO) | (1 << `DIC_CTRL_EXT_LO));
        rd(`DIC_REG_OCEN, 0);
        rd(`DIC_REG_THR, 1);
        apb(0, 12'h020, 0);
        chk(er, 1);
        open_detect <= 8'h04;
        tick(10);
        chk(chan_error, 0);
        apb(1, `DIC_REG_OCEN, 32'h04);
        tick(5);
        chk(chan_error[2], 1);
        apb(1, `DIC_REG_CTRL, 32'h42);
        inrush_start <= 1;
        tick(1);
        inrush_start <= 0;
        excess_current <= 1;
        tick(10);
        excess_current <= 0;
        supply_short <= 1;
        tick(10);
        chk(unit_error, 0);
        supply_short <= 0;
        tick(40);
        excess_current <= 1;
        tick(5);
        chk(unit_error, 1);
        excess_current <= 0;
        apb(1, `DIC_REG_CTRL, 32'h41);
        supply_short <= 1;
        tick(5);
        chk(unit_error, 1);
        restore_ch <= 1;
        restore_data <= 1000;
        restore_valid <= 1;
        tick(1);
        restore_valid <= 0;
        v = 100 + {$random(seed)} % 10000;
        gl <= v[15:0];
        tick(1);
        gl <= 0;
        tick(v + 20);
        chk(input_level, 0);
        lvl <= 8'hFF;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (input_level[0] !== 1'b1 && n < 30000);
        chk(n >= fcyc(0) && n <= fcyc(0) + 8, 1);
        chk(input_level, 8'hFF);
        apb(1, `DIC_REG_CNTSEL, 0);
        rd(`DIC_REG_CNT, 1);
        apb(1, `DIC_REG_CNTSEL, 1);
        rd(`DIC_REG_CNT, 1000 + 1);
        chk(chan_error[1:0], {1001 > `DIC_CNT_SCALE, 1 > `DIC_CNT_SCALE});
        apb(1, `DIC_REG_THR, 0);
        rd(`DIC_REG_THR, 1);
        for (int i = 0; i < 4; i++) begin
            v = 1 + {$random(seed)} % 65000;
            apb(1, `DIC_REG_THR, v);
            rd(`DIC_REG_THR, v);
        end
        apb(1, `DIC_REG_THR, 65001);
        rd(`DIC_REG_THR, v);
        n = 0;
        while (!(save_req === 1'b1 && save_ch === 8'h01) && n < 20000) begin
            tick(1);
            n++;
        end
        chk(save_data, 1001);
        final_report();
    end
endmodule
`default_nettype wire
